// ---- hdl/upc_pkg.sv ----
// Purpose: Shared constants for the UART parameter, checksum and address-match block
// Assumes: 32-bit AXI4-Lite data, one word per register index
// Notes:   Byte address of a register is four times its index

// ============================================================
// Package
package upc_pkg;
  // Register indices; byte address = index * 4
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned IDX_W      = 10;
  localparam logic [IDX_W-1:0] IDX_RXTOP   = 10'h2a1;
  localparam logic [IDX_W-1:0] IDX_RXSUM   = 10'h2a2;
  localparam logic [IDX_W-1:0] IDX_TXBOT   = 10'h2a3;
  localparam logic [IDX_W-1:0] IDX_TXSUM   = 10'h2a4;
  localparam logic [IDX_W-1:0] IDX_PARAM1  = 10'h2a5;
  localparam logic [IDX_W-1:0] IDX_PARAM2  = 10'h2a7;
  localparam logic [IDX_W-1:0] IDX_PARAM3  = 10'h2a9;
  localparam logic [IDX_W-1:0] IDX_CTL0    = 10'h2ab;
  localparam logic [IDX_W-1:0] IDX_CTL1    = 10'h2ac;
  localparam logic [IDX_W-1:0] IDX_CTL2    = 10'h2ad;
  localparam logic [IDX_W-1:0] IDX_BAUD    = 10'h2ae;
  localparam logic [IDX_W-1:0] IDX_FIFO    = 10'h2b0;
  localparam logic [IDX_W-1:0] IDX_WAKE    = 10'h2b1;
  localparam logic [IDX_W-1:0] IDX_ERRF    = 10'h2b2;
  localparam logic [IDX_W-1:0] IDX_ERRE    = 10'h2b3;
  localparam logic [IDX_W-1:0] IDX_IRQ_ST  = 10'h2b8;
  localparam logic [IDX_W-1:0] IDX_IRQ_MSK = 10'h2b9;
  localparam logic [IDX_W-1:0] IDX_MATCH   = 10'h2ba;

  // Plain byte registers held in one array
  localparam int unsigned NPLAIN = 7;
  localparam logic [IDX_W-1:0] PLAIN_IDX [NPLAIN] =
    '{IDX_CTL0, IDX_CTL1, IDX_CTL2, IDX_FIFO, IDX_WAKE, IDX_ERRF, IDX_ERRE};
  localparam int unsigned PL_CTL0 = 0;
  localparam int unsigned PL_CTL2 = 2;

  // Field positions
  localparam int unsigned MODE_LSB    = 0;
  localparam int unsigned MODE_W      = 4;
  localparam int unsigned CHKEN_BIT   = 3;
  localparam int unsigned PARAM_W     = 9;
  localparam int unsigned PARAM_MSB   = 8;

  // Operating modes (mode field of control_zero)
  localparam logic [3:0] MODE_ASYNC_ADDR = 4'h4;
  localparam logic [3:0] MODE_DMX        = 4'ha;
  localparam logic [3:0] MODE_LIN_CLIENT = 4'hb;
  localparam logic [3:0] MODE_LIN_HOST   = 4'hc;

  // Interrupt status bits
  localparam int unsigned NIRQ       = 3;
  localparam int unsigned IRQ_RXBYTE = 0;
  localparam int unsigned IRQ_TXBYTE = 1;
  localparam int unsigned IRQ_MATCH  = 2;

  // Reset values and bus answers
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [8:0]  PARAM_RST = 9'h000;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;
endpackage : upc_pkg

// ---- hdl/upc_checksum.sv ----
// Purpose: One running 8-bit checksum with software write access
// Assumes: Byte strobes come from logic on the same clock
// Notes:   Used twice, once for receive and once for transmit

`timescale 1ns/1ps

// ============================================================
// Checksum accumulator
module upc_checksum
  import upc_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // Software access
  input  wire logic       sw_wr,
  input  wire logic [7:0] sw_data,
  // Byte stream
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  input  wire logic       byte_is_pid,
  // Configuration
  input  wire logic       lin_mode,
  input  wire logic       chk_enable,
  // Result
  output logic      [7:0] sum
);
  logic       take;
  logic [7:0] base;

  // LIN: enable picks enhanced (with PID) or classic; elsewhere enable gates
  assign take = byte_valid && (lin_mode ? (chk_enable || !byte_is_pid) : chk_enable);
  // A write and a byte in one cycle both count: the byte adds onto the write
  assign base = sw_wr ? sw_data : sum;

  // Modulo 256 sum, carry dropped by the 8-bit target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sum <= BYTE_RST;
    end else if (ce) begin
      if (take) begin
        sum <= 8'(base + byte_data);
      end else if (sw_wr) begin
        sum <= sw_data;
      end
    end
  end
endmodule : upc_checksum

// ---- hdl/upc_top.sv ----
// Purpose: UART parameter words, running checksums and address match, AXI4-Lite mapped
// Assumes: Framing, FIFOs and baud logic sit outside and feed byte strobes on aclk
// Notes:   Register byte address is four times the register index
//
// How it works
// R1 - DMX: nine-bit parameter three, bit 8 top, is the last captured channel.
// R2 - LIN client: parameter three low byte is the expected received data count.
// R3 - Address mode: (address XOR param two low) AND param three low, zero means match.
// R4 - Bit 8 only used in DMX; low byte only in DMX, LIN client, address.
// R5 - Parameter three is reached as separate high (bit 8) and low byte lanes.
// R6 - LIN with enable set: transmit sum includes the protected identifier.
// R7 - LIN with enable clear: transmit sum excludes the protected identifier.
// R8 - Other modes with enable set: transmit sum adds every byte since clearing.
// R9 - LIN with enable set: receive sum includes the protected identifier.
// R10 - LIN with enable clear: receive sum excludes the protected identifier.
// R11 - Other modes with enable set: receive sum adds every byte since clearing.
// R12 - Both sums are 8-bit, read/write, reset to zero.
// R13 - Address mode sends parameter one low byte with ninth bit set.
// R14 - Sums wrap modulo 256; writing zero clears a sum.
// R15 - Only characters with ninth bit set update the match state.
//
// Implementation choice: the AXI4-Lite slave port.

`timescale 1ns/1ps

// ============================================================
// Top level
module upc_top
  import upc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Receive byte stream from the framer
  input  wire logic              rx_byte_valid,
  input  wire logic [7:0]        rx_byte,
  input  wire logic              rx_ninth,
  input  wire logic              rx_is_pid,
  // Transmit byte stream from the framer
  input  wire logic              tx_byte_valid,
  input  wire logic [7:0]        tx_byte,
  input  wire logic              tx_is_pid,
  // Configuration to the framer
  output logic [MODE_W-1:0]      mode,
  output logic                   checksum_enable,
  output logic [PARAM_W-1:0]     dmx_last_addr,
  output logic [7:0]             lin_rx_count,
  output logic [PARAM_W-1:0]     tx_addr_char,
  output logic                   addr_match,
  // Interrupt
  output logic                   irq
);

  // ============================================================
  // Declarations
  logic [ADDR_W-1:0]  aw_addr_reg;
  logic               aw_got_reg;
  logic [31:0]        w_data_reg;
  logic [3:0]         w_strb_reg;
  logic               w_got_reg;
  logic               do_write;
  logic [IDX_W-1:0]   w_idx;
  logic [IDX_W-1:0]   r_idx;
  logic               rd_take;
  logic [7:0]         plain_reg [NPLAIN];
  logic [PARAM_W-1:0] param1_reg;
  logic [PARAM_W-1:0] param2_reg;
  logic [PARAM_W-1:0] param3_reg;
  logic [15:0]        baud_reg;
  logic [7:0]         txbot_reg;
  logic [7:0]         rxtop_reg;
  logic [NIRQ-1:0]    irq_st_reg;
  logic [NIRQ-1:0]    irq_msk_reg;
  logic [NIRQ-1:0]    irq_set;
  logic [7:0]         rx_sum;
  logic [7:0]         tx_sum;
  logic [MODE_W-1:0]  cur_mode;
  logic               chk_en;
  logic               lin_mode;
  logic               addr_mode;
  logic               match_now;
  logic [31:0]        rd_word;
  logic               rd_hit;

  assign w_idx    = aw_addr_reg[ADDR_W-1:2];
  assign r_idx    = s_axi_araddr[ADDR_W-1:2];
  assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign rd_take  = s_axi_arvalid && s_axi_arready;

  // Mode decode from the stored control bytes
  assign cur_mode  = plain_reg[PL_CTL0][MODE_LSB +: MODE_W];
  assign chk_en    = plain_reg[PL_CTL2][CHKEN_BIT];
  assign lin_mode  = (cur_mode == MODE_LIN_CLIENT) || (cur_mode == MODE_LIN_HOST);
  assign addr_mode = (cur_mode == MODE_ASYNC_ADDR);

  // Masked comparison; masked-off bits never spoil a match
  assign match_now = ((rx_byte ^ param2_reg[7:0]) & param3_reg[7:0]) == 8'h00; // R3

  // ============================================================
  // AXI write channels: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg    <= 1'b0;
      aw_addr_reg   <= '0;
      s_axi_awready <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        aw_got_reg    <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_got_reg <= 1'b0;
      end else if (!aw_got_reg && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // Write data holder
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_reg    <= 1'b0;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_got_reg    <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_got_reg <= 1'b0;
      end else if (!w_got_reg && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response; unmapped indices answer SLVERR, nothing stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= map_hit(w_idx) ? RESP_OKAY : RESP_SLV;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ============================================================
  // Register storage
  function automatic logic map_hit(input logic [IDX_W-1:0] idx);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < NPLAIN; k++) begin
      if (idx == PLAIN_IDX[k]) begin
        hit = 1'b1;
      end
    end
    case (idx)
      IDX_RXTOP, IDX_RXSUM, IDX_TXBOT, IDX_TXSUM, IDX_PARAM1, IDX_PARAM2,
      IDX_PARAM3, IDX_BAUD, IDX_IRQ_ST, IDX_IRQ_MSK, IDX_MATCH: hit = 1'b1;
      default: ;
    endcase
    return hit;
  endfunction : map_hit

  // Control and flag bytes, one entry per index, low lane only
  for (genvar g = 0; g < NPLAIN; g++) begin : g_plain
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        plain_reg[g] <= BYTE_RST;
      end else if (ce && do_write && w_idx == PLAIN_IDX[g] && w_strb_reg[0]) begin
        plain_reg[g] <= w_data_reg[7:0];
      end
    end
  end

  // Parameter words: lane 0 low byte, lane 1 carries bit 8 alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      param1_reg <= PARAM_RST;
      param2_reg <= PARAM_RST;
      param3_reg <= PARAM_RST;
    end else if (ce && do_write) begin
      if (w_idx == IDX_PARAM1 && w_strb_reg[0]) param1_reg[7:0] <= w_data_reg[7:0];
      if (w_idx == IDX_PARAM1 && w_strb_reg[1]) param1_reg[PARAM_MSB] <= w_data_reg[8];
      if (w_idx == IDX_PARAM2 && w_strb_reg[0]) param2_reg[7:0] <= w_data_reg[7:0];
      if (w_idx == IDX_PARAM2 && w_strb_reg[1]) param2_reg[PARAM_MSB] <= w_data_reg[8];
      if (w_idx == IDX_PARAM3 && w_strb_reg[0]) param3_reg[7:0] <= w_data_reg[7:0]; // R5
      if (w_idx == IDX_PARAM3 && w_strb_reg[1]) param3_reg[PARAM_MSB] <= w_data_reg[8]; // R5
    end
  end

  // Baud divisor and transmit byte; only stored here and read back over the bus, not sent to the framer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_reg  <= '0;
      txbot_reg <= BYTE_RST;
    end else if (ce && do_write) begin
      if (w_idx == IDX_BAUD && w_strb_reg[0]) baud_reg[7:0] <= w_data_reg[7:0];
      if (w_idx == IDX_BAUD && w_strb_reg[1]) baud_reg[15:8] <= w_data_reg[15:8];
      if (w_idx == IDX_TXBOT && w_strb_reg[0]) txbot_reg <= w_data_reg[7:0];
    end
  end

  // Last received byte shown at the receive register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxtop_reg <= BYTE_RST;
    end else if (ce && rx_byte_valid) begin
      rxtop_reg <= rx_byte;
    end
  end

  // ============================================================
  // Running checksums
  upc_checksum u_rx_sum (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ce          (ce),
    .sw_wr       (do_write && w_idx == IDX_RXSUM && w_strb_reg[0]), // R12 R14
    .sw_data     (w_data_reg[7:0]),
    .byte_valid  (rx_byte_valid), // R9 R10 R11
    .byte_data   (rx_byte),
    .byte_is_pid (rx_is_pid),
    .lin_mode    (lin_mode),
    .chk_enable  (chk_en),
    .sum         (rx_sum)
  );

  upc_checksum u_tx_sum (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ce          (ce),
    .sw_wr       (do_write && w_idx == IDX_TXSUM && w_strb_reg[0]), // R12 R14
    .sw_data     (w_data_reg[7:0]),
    .byte_valid  (tx_byte_valid), // R6 R7 R8
    .byte_data   (tx_byte),
    .byte_is_pid (tx_is_pid),
    .lin_mode    (lin_mode),
    .chk_enable  (chk_en),
    .sum         (tx_sum)
  );

  // ============================================================
  // Address match and framer configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_match <= 1'b0;
    end else if (ce && addr_mode && rx_byte_valid && rx_ninth) begin // R15
      addr_match <= match_now; // R3
    end
  end

  // Parameter fields only reach the framer in the modes that use them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode            <= '0;
      checksum_enable <= 1'b0;
      dmx_last_addr   <= PARAM_RST;
      lin_rx_count    <= BYTE_RST;
      tx_addr_char    <= PARAM_RST;
    end else if (ce) begin
      mode            <= cur_mode;
      checksum_enable <= chk_en;
      dmx_last_addr   <= (cur_mode == MODE_DMX) ? param3_reg : PARAM_RST; // R1 R4
      lin_rx_count    <= (cur_mode == MODE_LIN_CLIENT) ? param3_reg[7:0] : BYTE_RST; // R2 R4
      tx_addr_char    <= addr_mode ? {1'b1, param1_reg[7:0]} : PARAM_RST; // R13
    end
  end

  // ============================================================
  // Interrupts: sticky status, cleared by reading it; a new event wins
  assign irq_set[IRQ_RXBYTE] = rx_byte_valid;
  assign irq_set[IRQ_TXBYTE] = tx_byte_valid;
  assign irq_set[IRQ_MATCH]  = addr_mode && rx_byte_valid && rx_ninth && match_now;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_reg <= '0;
    end else if (ce) begin
      if (rd_take && r_idx == IDX_IRQ_ST) begin
        irq_st_reg <= irq_set;
      end else begin
        irq_st_reg <= irq_st_reg | irq_set;
      end
    end
  end

  // Mask register and level output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_msk_reg <= '0;
      irq         <= 1'b0;
    end else if (ce) begin
      if (do_write && w_idx == IDX_IRQ_MSK && w_strb_reg[0]) begin
        irq_msk_reg <= w_data_reg[NIRQ-1:0];
      end
      irq <= |(irq_st_reg & irq_msk_reg);
    end
  end

  // ============================================================
  // Read path: answer one cycle after the address is taken
  always_comb begin
    rd_word = '0;
    rd_hit  = map_hit(r_idx);
    for (int k = 0; k < NPLAIN; k++) begin
      if (r_idx == PLAIN_IDX[k]) begin
        rd_word[7:0] = plain_reg[k];
      end
    end
    case (r_idx)
      IDX_RXTOP:   rd_word[7:0] = rxtop_reg;
      IDX_RXSUM:   rd_word[7:0] = rx_sum; // R12
      IDX_TXBOT:   rd_word[7:0] = txbot_reg;
      IDX_TXSUM:   rd_word[7:0] = tx_sum; // R12
      IDX_PARAM1:  rd_word[8:0] = param1_reg;
      IDX_PARAM2:  rd_word[8:0] = param2_reg;
      IDX_PARAM3:  rd_word[8:0] = param3_reg; // R5
      IDX_BAUD:    rd_word[15:0] = baud_reg;
      IDX_IRQ_ST:  rd_word[NIRQ-1:0] = irq_st_reg;
      IDX_IRQ_MSK: rd_word[NIRQ-1:0] = irq_msk_reg;
      IDX_MATCH:   rd_word[0] = addr_match;
      default: ;
    endcase
  end

  // Read channel handshake; one read in flight at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLV;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : upc_top

// ---- verification/upc_props.sv ----
// Purpose: Port-level checker for upc_top
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound into every upc_top instance

`timescale 1ns/1ps

// ============================================================
// Checker
module upc_props
  import upc_pkg::*;
(
  // Clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               ce,
  // Bus handshakes
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  // Byte stream and configuration
  input wire logic               rx_byte_valid,
  input wire logic               rx_ninth,
  input wire logic               rx_is_pid,
  input wire logic [MODE_W-1:0]  mode,
  input wire logic [PARAM_W-1:0] dmx_last_addr,
  input wire logic [7:0]         lin_rx_count,
  input wire logic [PARAM_W-1:0] tx_addr_char,
  input wire logic               addr_match,
  input wire logic               irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Bus answers stand until taken, follow a read address next cycle, block new writes
  AST_B_HOLD: assert property (ce && s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_R_HOLD: assert property (ce && s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_AR_LAT: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");

  // Parameter outputs follow the mode
  AST_DMX_ZERO: assert property (
    (ce && mode != MODE_DMX)[*2] |-> dmx_last_addr == '0) else $error("last channel leaked");
  AST_LIN_ZERO: assert property (
    (ce && mode != MODE_LIN_CLIENT)[*2] |-> lin_rx_count == '0) else $error("count leaked");
  AST_ADDR_NINTH: assert property (
    (ce && mode == MODE_ASYNC_ADDR)[*2] |-> tx_addr_char[PARAM_MSB]) else $error("ninth low");

  // Match state moves only on address characters in address mode
  AST_MATCH_HOLD: assert property (
    !(ce && rx_byte_valid && rx_ninth && mode == MODE_ASYNC_ADDR) |=> $stable(addr_match))
    else $error("match changed without address");

  // Main scenarios
  cover property (rx_byte_valid && rx_is_pid);
  cover property ($rose(addr_match));
  cover property ($rose(irq));
endmodule : upc_props

bind upc_top upc_props i_upc_props (.*);

// ---- verification/upc_node.sv ----
// Purpose: Far-side serial node presenting framed characters as byte strobes
// Assumes: Strobes change just after a rising edge
// Notes:   Idle byte lines show the inverse of the last character

`timescale 1ns/1ps

// ============================================================
// Node model
module upc_node
(
  // Clock
  input wire logic aclk,
  // Received character strobes
  output logic       rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic       rx_ninth,
  output logic       rx_is_pid,
  // Transmitted character strobes
  output logic       tx_byte_valid,
  output logic [7:0] tx_byte,
  output logic       tx_is_pid
);
  // Quiet line at start
  initial begin
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    rx_ninth = 1'b0;
    rx_is_pid = 1'b0;
    tx_byte_valid = 1'b0;
    tx_byte = 8'h00;
    tx_is_pid = 1'b0;
  end

  // One character on both streams; stale data is scrambled so it cannot pass
  task automatic put(input logic [7:0] b, input logic n9, input logic p);
    @(posedge aclk);
    rx_byte <= b;
    rx_ninth <= n9;
    rx_is_pid <= p;
    rx_byte_valid <= 1'b1;
    tx_byte <= b;
    tx_is_pid <= p;
    tx_byte_valid <= 1'b1;
    @(posedge aclk);
    rx_byte_valid <= 1'b0;
    tx_byte_valid <= 1'b0;
    rx_byte <= ~b;
    tx_byte <= ~b;
    rx_ninth <= ~n9;
    rx_is_pid <= ~p;
    tx_is_pid <= ~p;
  endtask : put
endmodule : upc_node

// ---- verification/upc_top_tb.sv ----
// Purpose: Self-checking bench for upc_top
// Assumes: Clock enable low only in the freeze check
// Notes:   Register byte address is the index shifted left by two

`timescale 1ns/1ps

// ============================================================
// Bench
module upc_top_tb
  import upc_pkg::*;
;
  logic                aclk, aresetn, ce;
  logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]         s_axi_wdata, s_axi_rdata;
  logic [3:0]          s_axi_wstrb, wst;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                s_axi_rvalid, s_axi_rready, checksum_enable, addr_match, irq;
  logic                rx_byte_valid, rx_ninth, rx_is_pid, tx_byte_valid, tx_is_pid;
  logic [7:0]          rx_byte, tx_byte, lin_rx_count;
  logic [MODE_W-1:0]   mode;
  logic [PARAM_W-1:0]  dmx_last_addr, tx_addr_char;
  int                  err_count, n_checks;

  upc_top  i_upc_top (.*);
  upc_node i_upc_node (.*);

  // 100 MHz clock
  always #5 aclk = ~aclk;

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ============================================================
  // Bus tasks; a dead slave hangs the wait until the watchdog fires
  task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= wst;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bvalid), 32'h1);
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [IDX_W-1:0] i, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rvalid), 32'h1);
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rd

  // ============================================================
  // Scenarios
  task automatic t_reset;
    rd(IDX_RXSUM, 32'h0, RESP_OKAY);
    rd(IDX_TXSUM, 32'h0, RESP_OKAY);
    rd(IDX_PARAM3, 32'h0, RESP_OKAY);
    wr(IDX_RXSUM, 32'h3c, RESP_OKAY);
    rd(IDX_RXSUM, 32'h3c, RESP_OKAY);
    wr(10'h3ff, 32'h1, RESP_SLV);
    rd(10'h3ff, 32'h0, RESP_SLV);
  endtask : t_reset

  task automatic t_param;
    wr(IDX_PARAM3, 32'h1ab, RESP_OKAY);
    wst = 4'h1;
    wr(IDX_PARAM3, 32'h0fe, RESP_OKAY);
    wst = 4'hf;
    rd(IDX_PARAM3, 32'h1fe, RESP_OKAY);
    wr(IDX_CTL0, 32'(MODE_DMX), RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(32'(dmx_last_addr), 32'h1fe);
    chk(32'(mode), 32'(MODE_DMX));
    chk(32'(lin_rx_count), 32'h0);
    wr(IDX_CTL0, 32'(MODE_LIN_CLIENT), RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(32'(lin_rx_count), 32'hfe);
    chk(32'(dmx_last_addr), 32'h0);
    wr(IDX_CTL0, 32'h0, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(32'(lin_rx_count | dmx_last_addr), 32'h0);
  endtask : t_param

  task automatic t_addr;
    wr(IDX_CTL0, 32'(MODE_ASYNC_ADDR), RESP_OKAY);
    wr(IDX_PARAM1, 32'h5a, RESP_OKAY);
    wr(IDX_PARAM2, 32'h35, RESP_OKAY);
    wr(IDX_PARAM3, 32'hf0, RESP_OKAY);
    wr(IDX_IRQ_MSK, 32'h4, RESP_OKAY);
    rd(IDX_IRQ_ST, 32'h0, RESP_OKAY);
    chk(32'(tx_addr_char), 32'h15a);
    i_upc_node.put(8'h3a, 1'b1, 1'b0);
    repeat (2) @(posedge aclk);
    chk(32'(addr_match), 32'h1);
    chk(32'(irq), 32'h1);
    i_upc_node.put(8'h00, 1'b0, 1'b0);
    repeat (2) @(posedge aclk);
    chk(32'(addr_match), 32'h1);
    rd(IDX_IRQ_ST, 32'h7, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    i_upc_node.put(8'hc5, 1'b1, 1'b0);
    repeat (2) @(posedge aclk);
    chk(32'(addr_match), 32'h0);
    chk(32'(irq), 32'h0);
    rd(IDX_MATCH, 32'h0, RESP_OKAY);
    // Frozen clock enable: a matching address must leave no trace
    ce <= 1'b0;
    i_upc_node.put(8'h3a, 1'b1, 1'b0);
    ce <= 1'b1;
    chk(32'(addr_match), 32'h0);
  endtask : t_addr

  // Three bytes, the first a protected identifier; full sum 0x195 wraps
  task automatic t_sum;
    logic [3:0] md [6];
    logic [5:0] enb;
    logic       lin;
    logic [7:0] e;
    md = '{MODE_LIN_HOST, MODE_LIN_CLIENT, MODE_DMX, 4'h0, MODE_LIN_HOST, MODE_ASYNC_ADDR};
    enb = 6'b100101;
    for (int k = 0; k < 6; k++) begin
      wr(IDX_CTL0, 32'(md[k]), RESP_OKAY);
      wr(IDX_CTL2, {28'h0, enb[k], 3'h0}, RESP_OKAY);
      wr(IDX_RXSUM, 32'h0, RESP_OKAY);
      wr(IDX_TXSUM, 32'h0, RESP_OKAY);
      i_upc_node.put(8'h80, 1'b0, 1'b1);
      i_upc_node.put(8'h90, 1'b0, 1'b0);
      i_upc_node.put(8'h85, 1'b0, 1'b0);
      lin = md[k] == MODE_LIN_HOST || md[k] == MODE_LIN_CLIENT;
      e = enb[k] ? 8'h95 : (lin ? 8'h15 : 8'h00);
      chk(32'(checksum_enable), 32'(enb[k]));
      rd(IDX_RXSUM, 32'(e), RESP_OKAY);
      rd(IDX_TXSUM, 32'(e), RESP_OKAY);
    end
  endtask : t_sum

  // Main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    ce = 1'b1;
    wst = 4'hf;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    err_count = 0;
    n_checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_param();
    t_addr();
    t_sum();
    conclude();
  end

  // Watchdog, well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule : upc_top_tb
